/* cabp_core_regs.v */
// accumulator, auxiliary multiply/divide register and status word for the cpu core
`timescale 1ns/1ps
`default_nettype none
`include "cabp_regs_map.vh"

// Function
// - 8-bit read/write accumulator at 0xe0, reset to 0x00, used by instructions.
// - each accumulator bit can be set, cleared or tested individually.
// - 8-bit read/write aux register at 0xf0, reset 0x00, multiply/divide operand.
// - each aux register bit can be set, cleared or tested individually.
// - status word at 0xd0, reset 0x00: cy,hcy,gp,bsh,bsl,ov,user,parity.
// - half-carry flag bit 6 takes low-nibble carry from arithmetic.
module cabp_core_regs
(
    input wire i_mclk,
    input wire i_sys_rst,
    input wire [7:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    input wire [7:0] i_bit_addr,
    input wire [1:0] i_bit_op,
    input wire [7:0] i_alu_a,
    input wire [7:0] i_alu_b,
    input wire i_alu_cin,
    input wire i_alu_sub,
    input wire i_alu_go,
    input wire i_md_go,
    input wire [7:0] i_md_acc,
    input wire [7:0] i_md_aux,
    input wire i_md_ovf,
    output reg [7:0] o_rdata,
    output reg o_bit_rdata,
    output reg [7:0] o_acc,
    output reg [7:0] o_aux,
    output reg [7:0] o_status,
    output reg [1:0] o_bank_sel
);
    reg [7:0] acc_r;
    reg [7:0] acc_nxt;
    reg [7:0] aux_r;
    reg [7:0] aux_nxt;
    reg [7:0] status_r;
    reg [7:0] status_nxt;
    reg [7:0] rdata_nxt;
    reg bit_nxt;
    wire [4:0] lo_sum;
    wire [8:0] full_sum;
    wire [7:0] b_eff;
    wire sig_ovf;
    wire [7:0] bit_base;
    wire [2:0] bit_pos;

    // bit address: upper five bits pick the byte register, low three the bit
    assign bit_base = {i_bit_addr[7:3], 3'h0};
    assign bit_pos = i_bit_addr[2:0];

    // subtract is add of inverted operand with inverted borrow, so one adder serves both
    assign b_eff = i_alu_sub ? ~i_alu_b : i_alu_b;
    assign lo_sum = {1'b0, i_alu_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, i_alu_cin ^ i_alu_sub};
    assign full_sum = {1'b0, i_alu_a} + {1'b0, b_eff} + {8'h00, i_alu_cin ^ i_alu_sub};
    assign sig_ovf = (i_alu_a[7] == b_eff[7]) && (full_sum[7] != i_alu_a[7]);

    // next state: byte writes first, then bit ops, then datapath updates win last
    always @*
    begin
        acc_nxt = acc_r;
        aux_nxt = aux_r;
        status_nxt = status_r;
        if (i_wr)
        begin
            if (i_addr == `CABP_ADDR_ACC)
                acc_nxt = i_wdata;
            else if (i_addr == `CABP_ADDR_AUX)
                aux_nxt = i_wdata;
            else if (i_addr == `CABP_ADDR_STATUS)
                status_nxt = i_wdata;
        end
        if (i_bit_op == `CABP_BITOP_SET || i_bit_op == `CABP_BITOP_CLR)
        begin
            if (bit_base == `CABP_ADDR_ACC)
                acc_nxt[bit_pos] = (i_bit_op == `CABP_BITOP_SET);
            else if (bit_base == `CABP_ADDR_AUX)
                aux_nxt[bit_pos] = (i_bit_op == `CABP_BITOP_SET);
            else if (bit_base == `CABP_ADDR_STATUS)
                status_nxt[bit_pos] = (i_bit_op == `CABP_BITOP_SET);
        end
        if (i_alu_go)
        begin
            acc_nxt = full_sum[7:0];
            status_nxt[`CABP_BIT_CY] = full_sum[8] ^ i_alu_sub;
            status_nxt[`CABP_BIT_HCY] = lo_sum[4] ^ i_alu_sub;
            status_nxt[`CABP_BIT_OVF] = sig_ovf;
        end
        else if (i_md_go)
        begin
            // multiply/divide results land in acc and aux; carry always clears
            acc_nxt = i_md_acc;
            aux_nxt = i_md_aux;
            status_nxt[`CABP_BIT_CY] = 1'b0;
            status_nxt[`CABP_BIT_OVF] = i_md_ovf;
        end
        // parity is not storable: always even parity of the new accumulator
        status_nxt[`CABP_BIT_PARITY] = ^acc_nxt;
    end

    // read mux; unmapped addresses return zero
    always @*
    begin
        rdata_nxt = 8'h00;
        if (i_rd)
        begin
            if (i_addr == `CABP_ADDR_ACC)
                rdata_nxt = acc_r;
            else if (i_addr == `CABP_ADDR_AUX)
                rdata_nxt = aux_r;
            else if (i_addr == `CABP_ADDR_STATUS)
                rdata_nxt = status_r;
        end
        bit_nxt = 1'b0;
        if (bit_base == `CABP_ADDR_ACC)
            bit_nxt = acc_r[bit_pos];
        else if (bit_base == `CABP_ADDR_AUX)
            bit_nxt = aux_r[bit_pos];
        else if (bit_base == `CABP_ADDR_STATUS)
            bit_nxt = status_r[bit_pos];
    end

    // state registers and registered outputs
    always @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            acc_r <= `CABP_RST_ACC;
            aux_r <= `CABP_RST_AUX;
            status_r <= `CABP_RST_STATUS;
            o_rdata <= 8'h00;
            o_bit_rdata <= 1'b0;
            o_acc <= `CABP_RST_ACC;
            o_aux <= `CABP_RST_AUX;
            o_status <= `CABP_RST_STATUS;
            o_bank_sel <= 2'h0;
        end
        else
        begin
            acc_r <= acc_nxt;
            aux_r <= aux_nxt;
            status_r <= status_nxt;
            o_rdata <= rdata_nxt;
            o_bit_rdata <= bit_nxt;
            o_acc <= acc_nxt;
            o_aux <= aux_nxt;
            o_status <= status_nxt;
            o_bank_sel <= {status_nxt[`CABP_BIT_BSH], status_nxt[`CABP_BIT_BSL]};
        end
    end
endmodule // cabp_core_regs
`default_nettype wire

/* cabp_regs_map.vh */
// register offsets, field positions and reset values for the core accumulator/aux/status registers
`ifndef CABP_REGS_MAP_VH
`define CABP_REGS_MAP_VH
`define CABP_ADDR_STATUS 8'hd0
`define CABP_ADDR_ACC 8'he0
`define CABP_ADDR_AUX 8'hf0
`define CABP_RST_STATUS 8'h00
`define CABP_RST_ACC 8'h00
`define CABP_RST_AUX 8'h00
`define CABP_BIT_PARITY 0
`define CABP_BIT_USER 1
`define CABP_BIT_OVF 2
`define CABP_BIT_BSL 3
`define CABP_BIT_BSH 4
`define CABP_BIT_GPF 5
`define CABP_BIT_HCY 6
`define CABP_BIT_CY 7
`define CABP_BITOP_SET 2'h1
`define CABP_BITOP_CLR 2'h2
`endif

/* cabp_asserts.sv */
// checker for the core register ports
`timescale 1ns/1ps
`default_nettype none
module cabp_chk (input wire i_mclk, input wire i_sys_rst, input wire i_wr, input wire i_alu_go, input wire i_md_go,
    input wire i_alu_cin, input wire i_alu_sub, input wire [1:0] i_bit_op, input wire [7:0] i_addr,
    input wire [7:0] i_wdata, input wire [7:0] i_bit_addr, input wire [7:0] i_alu_a, input wire [7:0] i_alu_b,
    input wire [7:0] o_acc, input wire [7:0] o_aux, input wire [7:0] o_status);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    // a byte write is only checked when no bit op, alu or multiply/divide strobe shares its cycle
    wire w = i_wr && !i_alu_go && !i_md_go && i_bit_op == 2'h0;
    property p_aw; w && i_addr == 8'he0 |=> o_acc == $past(i_wdata); endproperty
    a_aw: assert property (p_aw) else $error("acc write");
    property p_as; i_bit_op == 2'h1 && i_bit_addr[7:3] == 5'h1c && !i_alu_go && !i_md_go |=> o_acc[$past(i_bit_addr[2:0])];
    endproperty
    a_as: assert property (p_as) else $error("acc bit set");
    property p_bw; w && i_addr == 8'hf0 |=> o_aux == $past(i_wdata); endproperty
    a_bw: assert property (p_bw) else $error("aux write");
    property p_bc; i_bit_op == 2'h2 && i_bit_addr[7:3] == 5'h1e && !i_md_go |=> !o_aux[$past(i_bit_addr[2:0])]; endproperty
    a_bc: assert property (p_bc) else $error("aux bit clear");
    property p_sw; w && i_addr == 8'hd0 |=> o_status[7:1] == $past(i_wdata[7:1]); endproperty
    a_sw: assert property (p_sw) else $error("status write");
    property p_hc; i_alu_go && !i_alu_sub |=> o_status[6] == ($past({1'b0, i_alu_a[3:0]} + i_alu_b[3:0] + i_alu_cin) > 5'h0f);
    endproperty
    a_hc: assert property (p_hc) else $error("half carry");
    property p_pa; o_status[0] == ^o_acc; endproperty
    a_pa: assert property (p_pa) else $error("parity");
    c_alu: cover property (i_alu_go && !i_alu_sub);
    c_md: cover property (i_md_go);
    c_bit: cover property (i_bit_op == 2'h1);
endmodule // cabp_chk
bind cabp_core_regs cabp_chk chk_u (.*);
`default_nettype wire

/* cabp_core_regs_bench.sv */
// self-checking bench for the core registers
`timescale 1ns/1ps
`default_nettype none
`define CK(a, b) begin checks_done++; if ((a) !== (b)) \
    begin n_mismatch++; $display("[FAIL] %0t mismatch", $time); end end
module cabp_core_regs_bench;
    logic i_mclk = '0, i_sys_rst = 1'h1, i_wr = '0, i_rd = '0, i_alu_cin = '0, i_alu_sub = '0, i_alu_go = '0;
    logic i_md_go = '0, i_md_ovf = '0;
    logic [1:0] i_bit_op = '0;
    logic [7:0] i_addr = '0, i_wdata = '0, i_bit_addr = '0, i_alu_a = '0, i_alu_b = '0, i_md_acc = '0, i_md_aux = '0;
    logic [7:0] o_rdata, o_acc, o_aux, o_status, ea, e;
    logic [1:0] o_bank_sel;
    logic o_bit_rdata;
    logic [34:0] z;
    int n_mismatch = 0, checks_done = 0, seed = 32'h1de9;
    cabp_core_regs dut_u (.*);
    always #12.5 i_mclk = ~i_mclk;
    // expected {carry, acc}; subtract reports a borrow in the carry
    function automatic logic [8:0] f(logic [34:0] v);
        return v[17] ? {1'b0, v[34:27]} - v[26:19] - v[18] : v[34:27] + v[26:19] + v[18];
    endfunction
    // expected half carry: carry or borrow out of the low nibble
    function automatic logic h(logic [34:0] v);
        logic [4:0] s;
        s = v[17] ? {1'b0, v[30:27]} - v[22:19] - v[18] : {1'b0, v[30:27]} + v[22:19] + v[18];
        return s[4];
    endfunction
    // one strobe cycle {wr,rd,alu,md} with fresh random data on every operand
    task automatic cyc(input logic [3:0] k, input logic [1:0] b, input logic [7:0] a);
        @(posedge i_mclk);
        z = 35'({$random(seed), $random(seed)});
        {i_wr, i_rd, i_alu_go, i_md_go, i_bit_op, i_addr, i_bit_addr} <= {k, b, a, a};
        {i_alu_a, i_alu_b, i_alu_cin, i_alu_sub, i_md_acc, i_md_aux, i_md_ovf} <= z;
        i_wdata <= z[7:0];
        @(posedge i_mclk);
        {i_wr, i_rd, i_alu_go, i_md_go, i_bit_op} <= 6'h0;
        #1;
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge i_mclk);
        i_sys_rst <= 1'h0;
        cyc(4'h8, 2'h0, 8'h55);
        `CK({o_acc, o_aux, o_status}, 24'h0)
        cyc(4'h4, 2'h0, 8'h55);
        `CK(o_rdata, 8'h00)
        for (int i = 0; i < 8; i++)
        begin
            cyc(4'h8, 2'h0, 8'he0);
            ea = z[7:0];
            cyc(4'h8, 2'h0, 8'hf0);
            `CK(o_aux, z[7:0])
            cyc(4'h8, 2'h0, 8'hd0);
            e = {z[7:1], ^ea};
            `CK(o_bank_sel, z[4:3])
            cyc(4'h4, 2'h0, 8'hd0);
            `CK(o_rdata, e)
            cyc(4'h0, 2'h1, 8'he0 | 8'(i));
            `CK(o_acc, ea | (8'h01 << i))
            @(posedge i_mclk);
            #1 `CK(o_bit_rdata, 1'h1)
            cyc(4'h0, 2'h2, 8'hf0 | 8'(i));
            `CK(o_aux[i], 1'h0)
            cyc(4'h2, 2'h0, 8'h00);
            `CK({o_status[7], o_acc}, f(z))
            `CK(o_status[6], h(z))
            cyc(4'h1, 2'h0, 8'h00);
            `CK({o_acc, o_aux, o_status[7], o_status[2]}, {z[16:1], 1'h0, z[0]})
        end
        end_of_test;
    end
    // watchdog well beyond the roughly 140 cycles the sequence needs
    initial
    begin
        #100000;
        n_mismatch++;
        end_of_test;
    end
endmodule // cabp_core_regs_bench
`default_nettype wire
